// [rtl/ccp_pkg.sv]
// Constants, configuration and status types of the camera capture port.
// Contract
// - Selectable 8, 10, 12 or 14 data lines.
// - Embedded sync ignores syncs, uses eight lines.
// - Each pixel clock sample packs into 32 bits.
// - 8-bit: four bytes per word, first lowest.
// - 10-bit: two halves, bits 10-15 zero.
// - 12-bit: two halves, bits 12-15 zero.
// - 14-bit: two halves, bits 14-15 zero.
// - Four-word FIFO between capture and bus.
// - Overrun protection; overrun flushes, no data is overwritten.
// - Overrun or sync error flushes, awaits frame.
// - Complete word raises the DMA request.
// - Receiver only; camera drives all lines.
// - Active sync levels blank data; programmable polarity.
// - Sample on configured pixel clock edge.
// - Embedded sync forces the 8-bit width.
package ccp_pkg;

  localparam int DATA_W = 14;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int CNT_W = 3;

  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [7:0] CODE_LEAD = 8'hff;
  localparam logic [7:0] CODE_ZERO = 8'h00;

  // Masks that keep the sample bits of one 16-bit half.
  localparam logic [15:0] MASK_W8 = 16'h00ff;
  localparam logic [15:0] MASK_W10 = 16'h03ff;
  localparam logic [15:0] MASK_W12 = 16'h0fff;
  localparam logic [15:0] MASK_W14 = 16'h3fff;

  // Last packing position before a word is complete.
  localparam logic [1:0] LAST_POS_W8 = 2'h3;
  localparam logic [1:0] LAST_POS_HALF = 2'h1;

  typedef enum logic [1:0] {
    CCP_W8,
    CCP_W10,
    CCP_W12,
    CCP_W14
  } ccp_width_t;

  typedef struct packed {
    logic capture_en;
    ccp_width_t width;
    logic embedded_sync;
    logic line_active_high;
    logic frame_active_high;
    logic sample_rising;
    logic [7:0] frame_start_code;
  } ccp_cfg_t;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic valid;
  } ccp_rd_t;

  typedef struct packed {
    logic waiting_frame;
    logic overrun;
    logic sync_error;
  } ccp_status_t;

endpackage : ccp_pkg

// [rtl/ccp_capture_port.sv]
// Camera capture port: pin sampling, word packing, FIFO and DMA request.
`timescale 1ns/1ps
module ccp_capture_port (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire ccp_pkg::ccp_cfg_t cfg,
  input wire logic pixel_clock_in,
  input wire logic line_sync_in,
  input wire logic frame_sync_in,
  input wire logic [ccp_pkg::DATA_W-1:0] pixel_data_in,
  input wire logic word_rd,
  output ccp_pkg::ccp_rd_t captured_pixel_word,
  output logic dma_req,
  output ccp_pkg::ccp_status_t status
);
  import ccp_pkg::*;

  typedef enum logic {FR_WAIT, FR_ACTIVE} ccp_frame_t;
  typedef enum logic [1:0] {CODE_IDLE, CODE_FF, CODE_Z1, CODE_Z2} ccp_code_t;

  // Places one sample at its packing position.
  function automatic logic [31:0] place(ccp_width_t w, logic [1:0] pos,
                                        logic [DATA_W-1:0] d);
    logic [15:0] half;
    logic [31:0] wide;
    logic [4:0] sh;
    half = {2'b00, d};
    case (w)
      CCP_W8: half = half & MASK_W8;
      CCP_W10: half = half & MASK_W10;
      CCP_W12: half = half & MASK_W12;
      default: half = half & MASK_W14;
    endcase
    wide = {16'h0000, half};
    if (w == CCP_W8) begin
      sh = {pos, 3'b000};
    end else begin
      sh = {pos[0], 4'b0000};
    end
    return wide << sh;
  endfunction : place

  // Reset release through two flip-flops.
  logic [1:0] rst_sync;
  wire rst_n = rst_sync[1];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // Pin synchronisers; the third clock stage only feeds edge detection.
  logic [2:0] pclk_s;
  logic [1:0] line_s;
  logic [1:0] frame_s;
  logic [DATA_W-1:0] data_s0;
  logic [DATA_W-1:0] data_s1;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pclk_s <= 3'h0;
      line_s <= 2'h0;
      frame_s <= 2'h0;
      data_s0 <= 14'h0000;
      data_s1 <= 14'h0000;
    end else begin
      pclk_s <= {pclk_s[1:0], pixel_clock_in};
      line_s <= {line_s[0], line_sync_in};
      frame_s <= {frame_s[0], frame_sync_in};
      data_s0 <= pixel_data_in;
      data_s1 <= data_s0;
    end
  end

  // The edge finder needs at least two core clocks per pixel clock phase.
  wire rise = pclk_s[1] & ~pclk_s[2];
  wire fall = ~pclk_s[1] & pclk_s[2];
  wire sample_edge = cfg.sample_rising ? rise : fall;

  // Embedded sync is only meaningful at eight lines, so force it.
  wire ccp_width_t eff_width = cfg.embedded_sync ? CCP_W8 : cfg.width;

  wire line_blank = (line_s[1] == cfg.line_active_high);
  wire frame_blank = (frame_s[1] == cfg.frame_active_high);

  logic frame_blank_reg;
  ccp_frame_t frame_reg;
  ccp_frame_t frame_next;
  ccp_code_t code_reg;
  ccp_code_t code_next;
  logic [1:0] pos_reg;
  logic [31:0] acc_reg;

  // Hardware frame start: vertical blanking ends.
  wire hw_frame_start = ~cfg.embedded_sync & frame_blank_reg & ~frame_blank;

  // Embedded code tracking over the low byte only.
  wire [7:0] byte_in = data_s1[7:0];
  wire emb_edge = cfg.embedded_sync & sample_edge;
  wire emb_data = (code_reg == CODE_IDLE) & (byte_in != CODE_LEAD);
  wire emb_frame_start = emb_edge & (code_reg == CODE_Z2) &
                         (byte_in == cfg.frame_start_code);
  wire emb_error = emb_edge & (byte_in != CODE_ZERO) &
                   ((code_reg == CODE_FF) | (code_reg == CODE_Z1));

  always_comb begin
    code_next = code_reg;
    if (emb_edge) begin
      case (code_reg)
        CODE_IDLE: code_next = (byte_in == CODE_LEAD) ? CODE_FF : CODE_IDLE;
        CODE_FF: code_next = (byte_in == CODE_ZERO) ? CODE_Z1 : CODE_IDLE;
        CODE_Z1: code_next = (byte_in == CODE_ZERO) ? CODE_Z2 : CODE_IDLE;
        default: code_next = CODE_IDLE;
      endcase
    end
  end

  wire frame_start = cfg.capture_en & (hw_frame_start | emb_frame_start);
  wire sync_error = emb_error;

  // Syncs blank data in hardware mode and are ignored in embedded mode.
  wire data_ok = cfg.embedded_sync ? emb_data : (~line_blank & ~frame_blank);
  wire sample_valid = sample_edge & data_ok & (frame_reg == FR_ACTIVE) &
                      ~frame_start;

  wire [1:0] last_pos = (eff_width == CCP_W8) ? LAST_POS_W8 : LAST_POS_HALF;
  wire [31:0] acc_merged = acc_reg | place(eff_width, pos_reg, data_s1);
  wire word_done = sample_valid & (pos_reg == last_pos);

  // FIFO between the pixel-rate packer and the bus reader.
  logic [31:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;

  wire fifo_full = (count_reg == CNT_W'(FIFO_DEPTH));
  wire fifo_empty = (count_reg == 3'h0);
  wire pop_req = word_rd & ~fifo_empty;
  // A fifth word with no read beside it is an overrun; all is flushed.
  wire overrun = word_done & fifo_full & ~pop_req;
  wire flush = overrun | sync_error | ~cfg.capture_en;
  wire pop = pop_req & ~flush;
  wire push = word_done & ~flush;

  wire [CNT_W-1:0] count_next = flush ? 3'h0 :
    CNT_W'(count_reg + CNT_W'(push) - CNT_W'(pop));

  always_comb begin
    frame_next = frame_reg;
    case (frame_reg)
      FR_WAIT: frame_next = frame_start ? FR_ACTIVE : FR_WAIT;
      FR_ACTIVE: frame_next = flush ? FR_WAIT : FR_ACTIVE;
      default: frame_next = FR_WAIT;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_reg <= FR_WAIT;
      code_reg <= CODE_IDLE;
      frame_blank_reg <= 1'b1;
    end else begin
      frame_reg <= frame_next;
      code_reg <= code_next;
      frame_blank_reg <= frame_blank;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg <= 2'h0;
      acc_reg <= WORD_RESET;
    end else if (frame_start | flush | word_done) begin
      pos_reg <= 2'h0;
      acc_reg <= WORD_RESET;
    end else if (sample_valid) begin
      pos_reg <= 2'(pos_reg + 2'h1);
      acc_reg <= acc_merged;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= acc_merged;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 2'h0;
      rd_ptr_reg <= 2'h0;
      count_reg <= 3'h0;
    end else begin
      count_reg <= count_next;
      if (flush) begin
        wr_ptr_reg <= 2'h0;
        rd_ptr_reg <= 2'h0;
      end else begin
        wr_ptr_reg <= push ? 2'(wr_ptr_reg + 2'h1) : wr_ptr_reg;
        rd_ptr_reg <= pop ? 2'(rd_ptr_reg + 2'h1) : rd_ptr_reg;
      end
    end
  end

  // Read answer, DMA request and status all come from flip-flops.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      captured_pixel_word <= '0;
      dma_req <= 1'b0;
      status <= '0;
    end else begin
      captured_pixel_word.valid <= pop;
      if (pop) begin
        captured_pixel_word.word <= fifo_mem[rd_ptr_reg];
      end
      dma_req <= (count_next != 3'h0);
      status.waiting_frame <= (frame_next == FR_WAIT);
      status.overrun <= overrun;
      status.sync_error <= sync_error;
    end
  end

  // All camera pins are inputs; nothing is driven back.

endmodule : ccp_capture_port

// [tb/ccp_checker.sv]
// Concurrent checks on the camera capture port outputs.
`timescale 1ns/1ps
module ccp_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire ccp_pkg::ccp_cfg_t cfg,
  input wire logic word_rd,
  input wire ccp_pkg::ccp_rd_t captured_pixel_word,
  input wire logic dma_req,
  input wire ccp_pkg::ccp_status_t status
);
  import ccp_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_rd_answer; word_rd && dma_req && cfg.capture_en
    |=> captured_pixel_word.valid; endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read got no data");
  property p_valid_cause; captured_pixel_word.valid
    |-> $past(word_rd) && $past(dma_req); endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("data valid without a read");
  property p_word_hold; !captured_pixel_word.valid
    |-> $stable(captured_pixel_word.word); endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("read word changed without a pop");
  // A flush always leaves the port waiting for the next frame.
  property p_dma_fall; $fell(dma_req)
    |-> $past(word_rd) || status.waiting_frame; endproperty
  a_dma_fall: assert property (p_dma_fall)
    else $error("request dropped with words left");
  property p_rise_wait; $rose(dma_req)
    |-> !$past(status.waiting_frame, 2); endproperty
  a_rise_wait: assert property (p_rise_wait)
    else $error("word built before frame start");
  property p_ovr_flush; status.overrun |-> ##[0:2] !dma_req; endproperty
  a_ovr_flush: assert property (p_ovr_flush)
    else $error("overrun did not flush");
  property p_ovr_wait; status.overrun
    |-> ##[0:1] status.waiting_frame; endproperty
  a_ovr_wait: assert property (p_ovr_wait)
    else $error("overrun did not wait for frame");
  property p_en_low; !cfg.capture_en [*3] |-> !dma_req; endproperty
  a_en_low: assert property (p_en_low)
    else $error("request while capture disabled");
endmodule : ccp_checker

// [tb/ccp_camera_model.sv]
// Camera module model; it alone drives clock, syncs and data.
`timescale 1ns/1ps
module ccp_camera_model (
  input wire logic idle_level,
  output logic pixel_clock_in,
  output logic line_sync_in,
  output logic frame_sync_in,
  output logic [13:0] pixel_data_in
);
  logic phase = 1'b0;
  // The clock rests at the unsampled level between samples.
  assign pixel_clock_in = idle_level ^ phase;
  initial begin
    line_sync_in = 1'b0;
    frame_sync_in = 1'b0;
    pixel_data_in = 14'h0;
  end
  // 125 ns period keeps well under the core clock ratio.
  task automatic send(input logic [13:0] d, input logic blank);
    line_sync_in = blank;
    pixel_data_in = d;
    #62.5 phase = 1'b1;
    #62.5 phase = 1'b0;
    pixel_data_in = ~d;
  endtask : send
  task automatic frame(input logic act);
    frame_sync_in = act;
    #250 frame_sync_in = ~act;
    #250;
  endtask : frame
endmodule : ccp_camera_model

// [tb/testbench.sv]
// Self-checking bench for the camera capture port.
`timescale 1ns/1ps
module testbench;
  import ccp_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic word_rd = 1'b0;
  ccp_cfg_t cfg = '{1'b0, CCP_W8, 1'b0, 1'b1, 1'b1, 1'b1, 8'h80};
  wire idle_level = ~cfg.sample_rising;
  logic pixel_clock_in, line_sync_in, frame_sync_in, dma_req;
  logic [DATA_W-1:0] pixel_data_in;
  ccp_rd_t captured_pixel_word;
  ccp_status_t status;
  int bad_count = 0;
  int tests_run = 0;
  logic saw_ovr = 1'b0;
  logic saw_err = 1'b0;
  always #5 core_clk = ~core_clk;
  // Overrun and sync error are one-cycle pulses, so remember them here.
  always @(posedge core_clk) begin
    if (status.overrun === 1'b1) saw_ovr <= 1'b1;
    if (status.sync_error === 1'b1) saw_err <= 1'b1;
  end
  ccp_camera_model cam (
    .idle_level(idle_level),
    .pixel_clock_in(pixel_clock_in),
    .line_sync_in(line_sync_in),
    .frame_sync_in(frame_sync_in),
    .pixel_data_in(pixel_data_in)
  );
  ccp_capture_port dut (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .cfg(cfg),
    .pixel_clock_in(pixel_clock_in),
    .line_sync_in(line_sync_in),
    .frame_sync_in(frame_sync_in),
    .pixel_data_in(pixel_data_in),
    .word_rd(word_rd),
    .captured_pixel_word(captured_pixel_word),
    .dma_req(dma_req),
    .status(status)
  );
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(logic [31:0] e);
    @(negedge core_clk);
    for (int i = 0; i < 40 && dma_req !== 1'b1; i++) @(negedge core_clk);
    word_rd = 1'b1;
    @(negedge core_clk);
    word_rd = 1'b0;
    // The valid pulse stands for one cycle only, so look at it now.
    chk("valid", 32'h1, {31'h0, captured_pixel_word.valid});
    chk("word", e, captured_pixel_word.word);
  endtask : rd
  task automatic t_widths();
    logic [15:0] m;
    for (int w = 0; w < 4; w++) begin
      @(negedge core_clk);
      cfg.width = ccp_width_t'(w);
      cam.send(14'h2abc, 1'b0);
      cam.frame(1'b1);
      if (w == 0) begin
        for (int k = 1; k < 5; k++) cam.send(14'h3f00 | 14'(k * 17), 1'b0);
        rd(32'h4433_2211);
      end else begin
        m = (w == 1) ? MASK_W10 : (w == 2) ? MASK_W12 : MASK_W14;
        cam.send(14'h3a5c, 1'b0);
        cam.send(14'h1f37, 1'b0);
        rd({m & 16'h1f37, m & 16'h3a5c});
      end
    end
  endtask : t_widths
  task automatic t_fifo();
    cam.frame(1'b1);
    for (int k = 0; k < 8; k++) cam.send(14'(k + 1), 1'b0);
    for (int k = 0; k < 4; k++) rd({16'(2 * k + 2), 16'(2 * k + 1)});
    chk("dma_req", 32'h0, {31'h0, dma_req});
    chk("overrun", 32'h0, {31'h0, saw_ovr});
    for (int k = 0; k < 10; k++) cam.send(14'(k + 1), 1'b0);
    repeat (4) @(negedge core_clk);
    chk("waiting", 32'h1, {31'h0, status.waiting_frame});
    chk("overrun", 32'h1, {31'h0, saw_ovr});
    chk("dma_req", 32'h0, {31'h0, dma_req});
  endtask : t_fifo
  task automatic t_blank();
    @(negedge core_clk);
    cfg.width = CCP_W8;
    cfg.sample_rising = 1'b0;
    cfg.line_active_high = 1'b0;
    cfg.frame_active_high = 1'b0;
    cam.frame(1'b0);
    for (int k = 1; k < 10; k++) begin
      cam.send(14'(k), 1'(k != 2));
      if (k == 5) rd(32'h0504_0301);
    end
    @(negedge core_clk);
    chk("dma_req", 32'h1, {31'h0, dma_req});
    // Dropping the enable must throw the stored word away.
    cfg.capture_en = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("dma_req", 32'h0, {31'h0, dma_req});
    chk("waiting", 32'h1, {31'h0, status.waiting_frame});
    chk("sync_error", 32'h0, {31'h0, saw_err});
    cfg.capture_en = 1'b1;
  endtask : t_blank
  task automatic t_embed();
    logic [7:0] seq [14] = '{8'hff, 8'h00, 8'h00, 8'h80, 8'h01, 8'h02,
      8'h03, 8'h04, 8'hff, 8'h05, 8'h01, 8'h02, 8'h03, 8'h04};
    @(negedge core_clk);
    cfg.embedded_sync = 1'b1;
    cfg.width = CCP_W14;
    // Frame sync is left at its blanking level; it must not matter.
    cam.frame(1'b1);
    foreach (seq[k]) begin
      cam.send({6'h3f, seq[k]}, 1'b0);
      if (k == 7) rd(32'h0403_0201);
    end
    repeat (4) @(negedge core_clk);
    chk("dma_req", 32'h0, {31'h0, dma_req});
    chk("sync_error", 32'h1, {31'h0, saw_err});
  endtask : t_embed
  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (6) @(negedge core_clk);
    cfg.capture_en = 1'b1;
    t_widths();
    t_fifo();
    t_blank();
    t_embed();
    finish_test();
  end
  initial begin
    #200us;
    bad_count++;
    finish_test();
  end
endmodule : testbench
bind ccp_capture_port ccp_checker u_chk (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .cfg(cfg),
  .word_rd(word_rd),
  .captured_pixel_word(captured_pixel_word),
  .dma_req(dma_req),
  .status(status)
);
